// >>> common/mcg_pkg.sv
// Purpose: Shared constants for module clock gating and the configuration bank
// Assumes: One instruction cycle equals one i_clock period
// Notes: Behaviour list below is the contract of this block
//
// Behaviour
// - Configuration words are 24 bits; only the low 16 hold settings.
// - Four configuration words at F80000, F80002, F80004 and F8000A.
// - Software reads configuration words through table reads.
// - A set disable bit stops every clock to that peripheral.
// - Writes to a disabled peripheral's registers are ignored.
// - Peripheral enabled only if its bit is clear and it exists.
// - Disable bits reset to zero so present peripherals start enabled.
// - Setting a disable bit takes effect after one instruction cycle.
// - Clearing re-enables after one cycle if the peripheral asks to run.
// - Codec disable bit is read/write on variants that have the codec.
// - Low disable register at 0770 holds timer, codec, serial, CAN, ADC bits.
// - Register at 0772 holds capture 8..1 and compare 8..1 disable bits.
// - Oscillator word: monitor 15:14, source group 9:8, primary mode 3:0.
// - Watchdog word: hardware enable 15, prescale A 5:4, prescale B 3:0.
// - Reset word: clear pin 15, brown-out 7, level 5:4, power-up timer 1:0.
// - Code-protect word: read protect bit 1, write protect bit 0.
// - Debug enabled reserves the first 80 RAM bytes and two pins.
// - One of four debug pin pairs is selected: data line and clock line.
// - Debugger sends commands and data; device answers over the pair.
// - Primary debug pair shares the programming pins; alternates do not.
// - With hardware watchdog enable zero, software bit controls watchdog.
package mcg_pkg;
  localparam int NUM_PERIPH = 32;
  localparam int NUM_PAIRS = 4;
  localparam int OFF_DELAY_CYCLES = 1;
  // Register side
  localparam logic [15:0] PDL_ADDR = 16'h0770;
  localparam logic [15:0] CCD_ADDR = 16'h0772;
  localparam logic [15:0] PDL_RESET = 16'h0000;
  localparam logic [15:0] CCD_RESET = 16'h0000;
  localparam logic [15:0] PDL_IMPL_MASK = 16'hF9FF;
  localparam logic [15:0] CCD_IMPL_MASK = 16'hFFFF;
  localparam int CODEC_BIT = 8;
  localparam logic [31:0] PRESENT_DEFAULT = 32'hFFFF_F9FF;
  // Configuration space
  localparam logic [23:0] OSC_CFG_ADDR = 24'hF80000;
  localparam logic [23:0] WDT_CFG_ADDR = 24'hF80002;
  localparam logic [23:0] RST_CFG_ADDR = 24'hF80004;
  localparam logic [23:0] CPR_CFG_ADDR = 24'hF8000A;
  localparam logic [15:0] OSC_CFG_MASK = 16'hC30F;
  localparam logic [15:0] WDT_CFG_MASK = 16'h803F;
  localparam logic [15:0] RST_CFG_MASK = 16'h80B3;
  localparam logic [15:0] CPR_CFG_MASK = 16'h0003;
  localparam logic [15:0] CFG_ERASED = 16'hFFFF;
  localparam logic [7:0] CFG_UPPER = 8'h00;
  // Field positions
  localparam int CSM_LSB = 14;
  localparam int OSG_LSB = 8;
  localparam int POM_LSB = 0;
  localparam int WHE_BIT = 15;
  localparam int WPA_LSB = 4;
  localparam int WPB_LSB = 0;
  localparam int MCP_BIT = 15;
  localparam int BOE_BIT = 7;
  localparam int BOL_LSB = 4;
  localparam int PUT_LSB = 0;
  localparam int CRP_BIT = 1;
  localparam int CWP_BIT = 0;
  // Debug
  localparam logic [15:0] RAM_RESERVED_BYTES = 16'h0050;
  localparam logic [1:0] PRIMARY_PAIR = 2'h0;
endpackage

// >>> core/mcg_cfg_bank.sv
// Purpose: Non-volatile configuration word bank with table-read port
// Assumes: Programmer writes arrive synchronous to i_clock
// Notes: Reset models the erased state; a real array retains its contents
`timescale 1ns/100ps
`default_nettype none
module mcg_cfg_bank
  import mcg_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Programmer port
  input wire logic i_prog_we,
  input wire logic [23:0] i_prog_addr,
  input wire logic [23:0] i_prog_wdata,
  // Table read port
  input wire logic i_tbl_re,
  input wire logic [23:0] i_tbl_addr,
  output logic [23:0] o_tbl_rdata,
  output logic o_tbl_rvalid,
  // Stored words
  output logic [15:0] o_osc_word,
  output logic [15:0] o_wdt_word,
  output logic [15:0] o_rst_word,
  output logic [15:0] o_cpr_word
);
  typedef struct packed {
    logic [3:0][15:0] word;
    logic [23:0] rdata;
    logic rvalid;
  } mcg_bank_st_t;

  localparam logic [3:0][23:0] ADDRS = {CPR_CFG_ADDR, RST_CFG_ADDR,
    WDT_CFG_ADDR, OSC_CFG_ADDR};
  localparam logic [3:0][15:0] MASKS = {CPR_CFG_MASK, RST_CFG_MASK,
    WDT_CFG_MASK, OSC_CFG_MASK};

  mcg_bank_st_t st_ff;
  mcg_bank_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = i_tbl_re;
    nxt_st.rdata = 24'h000000;
    for (int k = 0; k < 4; k++) begin
      if (i_prog_we && i_prog_addr == ADDRS[k]) begin
        nxt_st.word[k] = i_prog_wdata[15:0] & MASKS[k];
      end
      if (i_tbl_re && i_tbl_addr == ADDRS[k]) begin
        nxt_st.rdata = {CFG_UPPER, st_ff.word[k]};
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '{word: {CFG_ERASED & CPR_CFG_MASK, CFG_ERASED & RST_CFG_MASK,
                 CFG_ERASED & WDT_CFG_MASK, CFG_ERASED & OSC_CFG_MASK},
                 rdata: 24'h000000, rvalid: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_tbl_rdata = st_ff.rdata;
  assign o_tbl_rvalid = st_ff.rvalid;
  assign o_osc_word = st_ff.word[0];
  assign o_wdt_word = st_ff.word[1];
  assign o_rst_word = st_ff.word[2];
  assign o_cpr_word = st_ff.word[3];

  tbl_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_tbl_re |=> o_tbl_rvalid && o_tbl_rdata[23:16] == 8'h00)
    else $error("table read missing or upper byte not zero");
endmodule
`default_nettype wire

// >>> core/mcg_gate.sv
// Purpose: One peripheral's clock enable and register enable
// Assumes: i_off comes straight from the disable register flip-flop
// Notes: Enables are registered, giving the one-cycle switching delay
`timescale 1ns/100ps
`default_nettype none
module mcg_gate
  import mcg_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Control
  input wire logic i_off,
  input wire logic i_present,
  input wire logic i_run_req,
  // Enables
  output logic o_clk_en,
  output logic o_regs_en
);
  typedef struct packed {
    logic clk_en;
    logic regs_en;
  } mcg_gate_st_t;

  mcg_gate_st_t st_ff;
  mcg_gate_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.clk_en = i_present && !i_off && i_run_req;
    nxt_st.regs_en = i_present && !i_off;
  end

  // Register access comes up enabled at reset; the clock enable starts off until the first edge
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '{clk_en: 1'b0, regs_en: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_clk_en = st_ff.clk_en;
  assign o_regs_en = st_ff.regs_en;

  off_delay_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    $rose(i_off) |=> !o_clk_en && !o_regs_en)
    else $error("peripheral still enabled one cycle after disable");
  on_delay_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!i_off && i_present && i_run_req) |=> o_clk_en)
    else $error("peripheral clock not restored after one cycle");
endmodule
`default_nettype wire

// >>> core/mcg_top.sv
// Purpose: Peripheral clock gating, configuration fields and debug pin pairs
// Assumes: SFR strobes are single-cycle and synchronous to i_clock
// Notes: Gating is expressed as clock enables, not gated clocks
`timescale 1ns/100ps
`default_nettype none
module mcg_top
  import mcg_pkg::*;
#(
  // Peripherals fitted on this variant; bit index equals disable bit index
  parameter logic [31:0] PRESENT_MASK = PRESENT_DEFAULT
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // SFR data-space access
  input wire logic [15:0] i_sfr_addr,
  input wire logic [15:0] i_sfr_wdata,
  input wire logic i_sfr_we,
  input wire logic i_sfr_re,
  output logic [15:0] o_sfr_rdata,
  output logic o_sfr_rvalid,
  // Peripheral register access qualification
  input wire logic i_sfr_periph_hit,
  input wire logic [4:0] i_sfr_periph_id,
  input wire logic [15:0] i_periph_rdata,
  output logic o_periph_we,
  // Peripheral clocks
  input wire logic [31:0] i_periph_run_req,
  output logic [31:0] o_periph_clk_en,
  output logic [31:0] o_periph_regs_en,
  // Table reads
  input wire logic i_tbl_re,
  input wire logic [23:0] i_tbl_addr,
  output logic [23:0] o_tbl_rdata,
  output logic o_tbl_rvalid,
  // Programmer
  input wire logic i_prog_we,
  input wire logic [23:0] i_prog_addr,
  input wire logic [23:0] i_prog_wdata,
  // Oscillator settings
  output logic [1:0] o_clock_switch_monitor_sel,
  output logic [1:0] o_osc_source_group,
  output logic [3:0] o_primary_osc_mode,
  // Watchdog settings
  output logic o_watchdog_hw_enable,
  output logic [1:0] o_watchdog_prescale_a,
  output logic [3:0] o_watchdog_prescale_b,
  input wire logic i_watchdog_sw_enable,
  output logic o_watchdog_enable,
  // Reset settings
  output logic o_master_clear_pin_enable,
  output logic o_brownout_enable,
  output logic [1:0] o_brownout_level,
  output logic [1:0] o_powerup_timer_sel,
  // Code protection
  output logic o_code_read_protect,
  output logic o_code_write_protect,
  // Debug control
  input wire logic i_debug_enable,
  input wire logic [1:0] i_debug_pair_sel,
  input wire logic [15:0] i_ram_addr,
  output logic o_ram_reserved_hit,
  output logic [3:0] o_debug_pair_active,
  output logic o_prog_pins_shared,
  // Debug pins, one per pair
  input wire logic [3:0] i_debug_data_pin,
  input wire logic [3:0] i_debug_clock_pin,
  output logic [3:0] o_debug_data_pin,
  output logic [3:0] o_debug_data_pin_oe,
  // Debug engine side
  input wire logic i_dbg_tx_data,
  input wire logic i_dbg_tx_oe,
  output logic o_dbg_rx_data,
  output logic o_dbg_rx_clk
);
  typedef struct packed {
    logic [15:0] pd_low;
    logic [15:0] cc_off;
    logic [15:0] rdata;
    logic rvalid;
    logic wdt_en;
    logic [3:0] pair_act;
    logic shared;
    logic [3:0] pin_o;
    logic [3:0] pin_oe;
    logic rx_data;
    logic rx_clk;
  } mcg_top_st_t;

  // Absent peripherals keep their bits at zero, so they read back as zero
  localparam logic [15:0] PDL_WMASK = PDL_IMPL_MASK & PRESENT_MASK[15:0];
  localparam logic [15:0] CCD_WMASK = CCD_IMPL_MASK & PRESENT_MASK[31:16];

  mcg_top_st_t st_ff;
  mcg_top_st_t nxt_st;
  logic pdl_hit;
  logic ccd_hit;
  logic periph_live;
  logic [31:0] off_vec;
  logic [15:0] osc_word;
  logic [15:0] wdt_word;
  logic [15:0] rst_word;
  logic [15:0] cpr_word;

  assign off_vec = {st_ff.cc_off, st_ff.pd_low};

  // One gate per disable bit
  for (genvar g = 0; g < NUM_PERIPH; g++) begin : gen_gate
    mcg_gate u_gate (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_off(off_vec[g]),
      .i_present(PRESENT_MASK[g]),
      .i_run_req(i_periph_run_req[g]),
      .o_clk_en(o_periph_clk_en[g]),
      .o_regs_en(o_periph_regs_en[g])
    );
  end

  mcg_cfg_bank u_bank (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_prog_we(i_prog_we),
    .i_prog_addr(i_prog_addr),
    .i_prog_wdata(i_prog_wdata),
    .i_tbl_re(i_tbl_re),
    .i_tbl_addr(i_tbl_addr),
    .o_tbl_rdata(o_tbl_rdata),
    .o_tbl_rvalid(o_tbl_rvalid),
    .o_osc_word(osc_word),
    .o_wdt_word(wdt_word),
    .o_rst_word(rst_word),
    .o_cpr_word(cpr_word)
  );

  assign pdl_hit = i_sfr_addr == PDL_ADDR;
  assign ccd_hit = i_sfr_addr == CCD_ADDR;
  // Own registers take precedence over an overlapping peripheral decode
  assign periph_live = i_sfr_periph_hit && !pdl_hit && !ccd_hit &&
                       o_periph_regs_en[i_sfr_periph_id];
  assign o_periph_we = i_sfr_we && periph_live;

  always_comb begin
    nxt_st = st_ff;
    if (i_sfr_we && pdl_hit) begin
      nxt_st.pd_low = i_sfr_wdata & PDL_WMASK;
    end
    if (i_sfr_we && ccd_hit) begin
      nxt_st.cc_off = i_sfr_wdata & CCD_WMASK;
    end
    nxt_st.rvalid = i_sfr_re;
    nxt_st.rdata = 16'h0000;
    if (i_sfr_re) begin
      if (pdl_hit) begin
        nxt_st.rdata = st_ff.pd_low;
      end else if (ccd_hit) begin
        nxt_st.rdata = st_ff.cc_off;
      end else if (periph_live) begin
        nxt_st.rdata = i_periph_rdata;
      end
    end
    // Software bit only matters while the hardware enable is off
    nxt_st.wdt_en = wdt_word[WHE_BIT] || i_watchdog_sw_enable;
    // Debug pair routing
    nxt_st.shared = i_debug_enable && i_debug_pair_sel == PRIMARY_PAIR;
    nxt_st.rx_data = 1'b0;
    nxt_st.rx_clk = 1'b0;
    for (int k = 0; k < NUM_PAIRS; k++) begin
      nxt_st.pair_act[k] = i_debug_enable &&
                           i_debug_pair_sel == k[1:0];
      nxt_st.pin_oe[k] = nxt_st.pair_act[k] && i_dbg_tx_oe;
      nxt_st.pin_o[k] = nxt_st.pair_act[k] && i_dbg_tx_data;
    end
    if (i_debug_enable) begin
      nxt_st.rx_data = i_debug_data_pin[i_debug_pair_sel];
      nxt_st.rx_clk = i_debug_clock_pin[i_debug_pair_sel];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '{pd_low: PDL_RESET, cc_off: CCD_RESET,
                 rdata: 16'h0000, rvalid: 1'b0, wdt_en: 1'b0,
                 pair_act: 4'h0, shared: 1'b0, pin_o: 4'h0,
                 pin_oe: 4'h0, rx_data: 1'b0, rx_clk: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Combinational so a reserved access can be blocked in its own cycle
  assign o_ram_reserved_hit = i_debug_enable &&
                              i_ram_addr < RAM_RESERVED_BYTES;

  assign o_sfr_rdata = st_ff.rdata;
  assign o_sfr_rvalid = st_ff.rvalid;
  assign o_watchdog_enable = st_ff.wdt_en;
  assign o_debug_pair_active = st_ff.pair_act;
  assign o_prog_pins_shared = st_ff.shared;
  assign o_debug_data_pin = st_ff.pin_o;
  assign o_debug_data_pin_oe = st_ff.pin_oe;
  assign o_dbg_rx_data = st_ff.rx_data;
  assign o_dbg_rx_clk = st_ff.rx_clk;

  // Field decode straight from stored words
  assign o_clock_switch_monitor_sel = osc_word[CSM_LSB +: 2];
  assign o_osc_source_group = osc_word[OSG_LSB +: 2];
  assign o_primary_osc_mode = osc_word[POM_LSB +: 4];
  assign o_watchdog_hw_enable = wdt_word[WHE_BIT];
  assign o_watchdog_prescale_a = wdt_word[WPA_LSB +: 2];
  assign o_watchdog_prescale_b = wdt_word[WPB_LSB +: 4];
  assign o_master_clear_pin_enable = rst_word[MCP_BIT];
  assign o_brownout_enable = rst_word[BOE_BIT];
  assign o_brownout_level = rst_word[BOL_LSB +: 2];
  assign o_powerup_timer_sel = rst_word[PUT_LSB +: 2];
  assign o_code_read_protect = cpr_word[CRP_BIT];
  assign o_code_write_protect = cpr_word[CWP_BIT];

  pdl_write_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_sfr_we && pdl_hit) |=>
      st_ff.pd_low == ($past(i_sfr_wdata) & PDL_WMASK))
    else $error("low disable register did not take the write");

  ccd_write_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_sfr_we && ccd_hit) |=>
      st_ff.cc_off == ($past(i_sfr_wdata) & CCD_WMASK))
    else $error("capture compare disable register did not take the write");

  blocked_write_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_periph_we == (i_sfr_we && i_sfr_periph_hit && !pdl_hit && !ccd_hit &&
                    o_periph_regs_en[i_sfr_periph_id]))
    else $error("peripheral write gating wrong");

  dead_read_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_sfr_re && i_sfr_periph_hit && !pdl_hit && !ccd_hit &&
     !o_periph_regs_en[i_sfr_periph_id]) |=>
      o_sfr_rvalid && o_sfr_rdata == 16'h0000)
    else $error("disabled peripheral read not zero");

  off_clock_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_sfr_we && pdl_hit && i_sfr_wdata[0] && PDL_WMASK[0]) |=>
      ##1 !o_periph_clk_en[0])
    else $error("clock still running after disable set");

  wdt_sw_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !o_watchdog_hw_enable && $stable(o_watchdog_hw_enable) |=>
      o_watchdog_enable == $past(i_watchdog_sw_enable))
    else $error("watchdog software enable not followed");

  pair_sel_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_debug_enable |=> $onehot(o_debug_pair_active) &&
      o_debug_pair_active[$past(i_debug_pair_sel)])
    else $error("debug pair selection not one-hot");

  shared_pins_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_prog_pins_shared == o_debug_pair_active[0])
    else $error("programming pin sharing mismatches primary pair");

  ram_reserve_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_debug_enable && (i_ram_addr == 16'h004F || i_ram_addr == 16'h0050)) |->
      o_ram_reserved_hit == (i_ram_addr == 16'h004F))
    else $error("debug RAM reservation boundary wrong");

  // Read path, peripheral presence and hardware watchdog
  sfr_answer_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_sfr_re |=> o_sfr_rvalid)
    else $error("read not answered");

  sfr_quiet_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !i_sfr_re |=> !o_sfr_rvalid && o_sfr_rdata == 16'h0000)
    else $error("idle read bus not zero");

  own_read_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_sfr_re && pdl_hit) |=> o_sfr_rdata == $past(st_ff.pd_low))
    else $error("low register read wrong");

  ccd_read_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_sfr_re && ccd_hit) |=> o_sfr_rdata == $past(st_ff.cc_off))
    else $error("compare register read wrong");

  live_read_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_sfr_re && periph_live) |=> o_sfr_rdata == $past(i_periph_rdata))
    else $error("peripheral read data lost");

  absent_clock_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_periph_clk_en & ~PRESENT_MASK) == 32'h0000_0000)
    else $error("absent peripheral clocked");

  wdt_hw_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_watchdog_hw_enable |=> o_watchdog_enable)
    else $error("hardware watchdog not on");

  // Debug pair routing and RAM reservation
  debug_idle_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !i_debug_enable |=>
      o_debug_pair_active == 4'h0 && o_debug_data_pin_oe == 4'h0)
    else $error("debug outputs active while off");

  ram_free_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !i_debug_enable |-> !o_ram_reserved_hit)
    else $error("RAM held while debug off");

  rx_data_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_debug_enable |=>
      o_dbg_rx_data == $past(i_debug_data_pin[i_debug_pair_sel]))
    else $error("debug data not routed");

  rx_clock_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_debug_enable |=>
      o_dbg_rx_clk == $past(i_debug_clock_pin[i_debug_pair_sel]))
    else $error("debug clock not routed");

  tx_oe_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_debug_enable |=> o_debug_data_pin_oe ==
      ({4{$past(i_dbg_tx_oe)}} & o_debug_pair_active))
    else $error("debug drive enable wrong");

  primary_pair_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_debug_enable |=>
      o_prog_pins_shared == ($past(i_debug_pair_sel) == PRIMARY_PAIR))
    else $error("pin sharing not primary pair");
endmodule
`default_nettype wire

// >>> sim/mcg_top_tb.sv
// Purpose: Self-checking bench for module clock gating and config bank
// Assumes: Default variant mask, codec fitted, bits 10 and 9 absent
// Notes: Inputs move 1 ns after the rising edge to keep races away
`timescale 1ns/100ps
`default_nettype none
module mcg_top_tb
  import mcg_pkg::*;
;
  logic i_clock, i_rst_n;
  logic [15:0] i_sfr_addr, i_sfr_wdata, i_periph_rdata, i_ram_addr;
  logic i_sfr_we, i_sfr_re, i_sfr_periph_hit, i_tbl_re, i_prog_we;
  logic [4:0] i_sfr_periph_id;
  logic [31:0] i_periph_run_req;
  logic [23:0] i_tbl_addr, i_prog_addr, i_prog_wdata;
  logic i_watchdog_sw_enable, i_debug_enable, i_dbg_tx_data, i_dbg_tx_oe;
  logic [1:0] i_debug_pair_sel;
  logic [3:0] i_debug_data_pin, i_debug_clock_pin;
  logic [15:0] o_sfr_rdata;
  logic o_sfr_rvalid, o_periph_we, o_tbl_rvalid;
  logic [31:0] o_periph_clk_en, o_periph_regs_en;
  logic [23:0] o_tbl_rdata;
  logic [1:0] o_csm, o_osg, o_wpa, o_bol, o_put;
  logic [3:0] o_pom, o_wpb, o_pair, o_dpin, o_dpin_oe;
  logic o_whe, o_wen, o_mcp, o_boe, o_crp, o_cwp;
  logic o_ram_hit, o_shared, o_rx_data, o_rx_clk;
  int mismatches = 0;
  int checks = 0;

  mcg_top i_mcg_top (
    .i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_we(i_sfr_we), .i_sfr_re(i_sfr_re),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_rvalid(o_sfr_rvalid),
    .i_sfr_periph_hit(i_sfr_periph_hit), .i_sfr_periph_id(i_sfr_periph_id),
    .i_periph_rdata(i_periph_rdata), .o_periph_we(o_periph_we),
    .i_periph_run_req(i_periph_run_req), .o_periph_clk_en(o_periph_clk_en),
    .o_periph_regs_en(o_periph_regs_en),
    .i_tbl_re(i_tbl_re), .i_tbl_addr(i_tbl_addr),
    .o_tbl_rdata(o_tbl_rdata), .o_tbl_rvalid(o_tbl_rvalid),
    .i_prog_we(i_prog_we), .i_prog_addr(i_prog_addr),
    .i_prog_wdata(i_prog_wdata),
    .o_clock_switch_monitor_sel(o_csm), .o_osc_source_group(o_osg),
    .o_primary_osc_mode(o_pom), .o_watchdog_hw_enable(o_whe),
    .o_watchdog_prescale_a(o_wpa), .o_watchdog_prescale_b(o_wpb),
    .i_watchdog_sw_enable(i_watchdog_sw_enable), .o_watchdog_enable(o_wen),
    .o_master_clear_pin_enable(o_mcp), .o_brownout_enable(o_boe),
    .o_brownout_level(o_bol), .o_powerup_timer_sel(o_put),
    .o_code_read_protect(o_crp), .o_code_write_protect(o_cwp),
    .i_debug_enable(i_debug_enable), .i_debug_pair_sel(i_debug_pair_sel),
    .i_ram_addr(i_ram_addr), .o_ram_reserved_hit(o_ram_hit),
    .o_debug_pair_active(o_pair), .o_prog_pins_shared(o_shared),
    .i_debug_data_pin(i_debug_data_pin),
    .i_debug_clock_pin(i_debug_clock_pin),
    .o_debug_data_pin(o_dpin), .o_debug_data_pin_oe(o_dpin_oe),
    .i_dbg_tx_data(i_dbg_tx_data), .i_dbg_tx_oe(i_dbg_tx_oe),
    .o_dbg_rx_data(o_rx_data), .o_dbg_rx_clk(o_rx_clk)
  );

  always #2 i_clock = ~i_clock;

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask

  // Every request starts one edge later so a strobe never toggles twice
  task automatic sfr_wr(input logic [15:0] a, input logic [15:0] d);
    tick();
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_we = 1'b1;
    tick();
    i_sfr_we = 1'b0;
  endtask

  task automatic sfr_rd(input logic [15:0] a, input logic [15:0] exp);
    tick();
    i_sfr_addr = a;
    i_sfr_re = 1'b1;
    tick();
    i_sfr_re = 1'b0;
    check("sfr_rvalid", o_sfr_rvalid, 1'b1);
    check("sfr_rdata", o_sfr_rdata, exp);
  endtask

  task automatic prog_wr(input logic [23:0] a, input logic [23:0] d);
    tick();
    i_prog_addr = a;
    i_prog_wdata = d;
    i_prog_we = 1'b1;
    tick();
    i_prog_we = 1'b0;
    tick();
  endtask

  task automatic tbl_rd(input logic [23:0] a, input logic [23:0] exp);
    tick();
    i_tbl_addr = a;
    i_tbl_re = 1'b1;
    tick();
    i_tbl_re = 1'b0;
    check("tbl_rvalid", o_tbl_rvalid, 1'b1);
    check("tbl_rdata", o_tbl_rdata, exp);
  endtask

  task automatic periph_acc(input logic [4:0] id, input logic en);
    tick();
    i_sfr_addr = 16'h0100;
    i_sfr_periph_hit = 1'b1;
    i_sfr_periph_id = id;
    i_sfr_we = 1'b1;
    #1 check("periph_we", o_periph_we, en);
    tick();
    i_sfr_we = 1'b0;
    i_sfr_re = 1'b1;
    tick();
    i_sfr_re = 1'b0;
    i_sfr_periph_hit = 1'b0;
    check("periph_rdata", o_sfr_rdata, en ? i_periph_rdata : 16'h0000);
  endtask

  task automatic test_reset();
    sfr_rd(PDL_ADDR, 16'h0000);
    sfr_rd(CCD_ADDR, 16'h0000);
    check("clk_en", o_periph_clk_en, PRESENT_DEFAULT);
    check("regs_en", o_periph_regs_en, PRESENT_DEFAULT);
    tbl_rd(OSC_CFG_ADDR, {8'h00, OSC_CFG_MASK});
    tbl_rd(CPR_CFG_ADDR, {8'h00, CPR_CFG_MASK});
    check("wdt_en", o_wen, 1'b1);
  endtask

  task automatic test_gate_timing();
    sfr_wr(PDL_ADDR, 16'h0001);
    check("clk_en0_hold", o_periph_clk_en[0], 1'b1);
    tick();
    check("clk_en0_off", o_periph_clk_en[0], 1'b0);
    check("regs_en0_off", o_periph_regs_en[0], 1'b0);
    i_periph_run_req[1] = 1'b0;
    sfr_wr(PDL_ADDR, 16'h0000);
    check("clk_en0_wait", o_periph_clk_en[0], 1'b0);
    tick();
    check("clk_en0_on", o_periph_clk_en[0], 1'b1);
    check("clk_en1_idle", o_periph_clk_en[1], 1'b0);
    check("regs_en1", o_periph_regs_en[1], 1'b1);
    i_periph_run_req[1] = 1'b1;
  endtask

  task automatic test_reg_map();
    sfr_wr(PDL_ADDR, 16'hFFFF);
    sfr_wr(CCD_ADDR, 16'hFFFF);
    tick();
    check("clk_en_all", o_periph_clk_en, 32'h0000_0000);
    sfr_rd(PDL_ADDR, 16'hF9FF);
    sfr_rd(CCD_ADDR, 16'hFFFF);
    sfr_wr(PDL_ADDR, 16'h0100);
    sfr_rd(PDL_ADDR, 16'h0100);
    sfr_rd(16'h0774, 16'h0000);
    sfr_wr(PDL_ADDR, 16'h0008);
    sfr_wr(CCD_ADDR, 16'h0000);
    tick();
    check("clk_en_map", o_periph_clk_en, PRESENT_DEFAULT & ~32'h8);
    periph_acc(5'h03, 1'b0);
    periph_acc(5'h04, 1'b1);
    periph_acc(5'h09, 1'b0);
    sfr_wr(PDL_ADDR, 16'h0000);
  endtask

  task automatic test_config();
    prog_wr(OSC_CFG_ADDR, 24'hFF5A5A);
    prog_wr(WDT_CFG_ADDR, 24'h000025);
    prog_wr(RST_CFG_ADDR, 24'h008091);
    prog_wr(CPR_CFG_ADDR, 24'h000002);
    prog_wr(24'hF80006, 24'h00FFFF);
    tbl_rd(OSC_CFG_ADDR, 24'h00420A);
    tbl_rd(WDT_CFG_ADDR, 24'h000025);
    tbl_rd(24'hF80006, 24'h000000);
    check("csm", o_csm, 2'h1);
    check("osg", o_osg, 2'h2);
    check("pom", o_pom, 4'hA);
    check("whe", o_whe, 1'b0);
    check("wpa", o_wpa, 2'h2);
    check("wpb", o_wpb, 4'h5);
    check("rst", {o_mcp, o_boe, o_bol, o_put}, 6'h35);
    check("cpr", {o_crp, o_cwp}, 2'h2);
    check("wdt_off", o_wen, 1'b0);
    i_watchdog_sw_enable = 1'b1;
    tick();
    tick();
    check("wdt_sw", o_wen, 1'b1);
  endtask

  task automatic test_debug();
    i_ram_addr = 16'h004F;
    tick();
    check("ram_hit79", o_ram_hit, 1'b1);
    i_ram_addr = RAM_RESERVED_BYTES;
    tick();
    check("ram_hit80", o_ram_hit, 1'b0);
    i_dbg_tx_data = 1'b1;
    i_dbg_tx_oe = 1'b1;
    for (int k = 0; k < NUM_PAIRS; k++) begin
      i_debug_pair_sel = k[1:0];
      i_debug_data_pin = 4'h1 << k;
      i_debug_clock_pin = ~(4'h1 << k);
      tick();
      tick();
      check("pair", o_pair, 4'h1 << k);
      check("shared", o_shared, k == 0);
      check("oe", o_dpin_oe, 4'h1 << k);
      check("dpin", o_dpin, 4'h1 << k);
      check("rx", {o_rx_data, o_rx_clk}, 2'h2);
    end
    i_debug_enable = 1'b0;
    tick();
    tick();
    check("pair_off", {o_pair, o_dpin_oe, o_rx_data}, 9'h000);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    i_clock = 1'b0;
    i_rst_n = 1'b0;
    {i_sfr_addr, i_sfr_wdata, i_ram_addr} = '0;
    {i_sfr_we, i_sfr_re, i_sfr_periph_hit, i_tbl_re, i_prog_we} = '0;
    i_periph_rdata = 16'hA5C3;
    i_sfr_periph_id = 5'h00;
    i_periph_run_req = 32'hFFFF_FFFF;
    {i_tbl_addr, i_prog_addr, i_prog_wdata} = '0;
    {i_watchdog_sw_enable, i_dbg_tx_data, i_dbg_tx_oe} = '0;
    i_debug_enable = 1'b1;
    i_debug_pair_sel = 2'h0;
    {i_debug_data_pin, i_debug_clock_pin} = '0;
    repeat (16) tick();
    i_rst_n = 1'b1;
    tick();
    test_reset();
    test_gate_timing();
    test_reg_map();
    test_config();
    test_debug();
    end_of_test();
  end

  // Whole run needs about a hundred cycles; far beyond that means a hang
  initial begin
    repeat (5000) @(posedge i_clock);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
